// File: rtl/dac_wr_pkg.sv
// constants shared by the parallel converter write front end
package dac_wr_pkg;

  // ----------------------------------------
  // data widths
  // ----------------------------------------
  localparam int CODE_W = 12;
  localparam int DATA_W = 8;
  localparam int LO_W   = 8;
  localparam int HI_W   = 4;
  localparam int CTRL_W = 3;
  localparam int SEL_W  = 2;

  // ----------------------------------------
  // destination select codes
  // ----------------------------------------
  localparam logic [1:0] SEL_LOWER = 2'h0;
  localparam logic [1:0] SEL_UPPER = 2'h1;
  localparam logic [1:0] SEL_RSVD  = 2'h2;
  localparam logic [1:0] SEL_CTRL  = 2'h3;

  // ----------------------------------------
  // control register fields and reset values
  // ----------------------------------------
  localparam int CTRL_SPEED_POS  = 0;
  localparam int CTRL_POWER_POS  = 1;
  localparam int CTRL_UPDATE_POS = 2;
  localparam logic [7:0]  LO_RST   = 8'h00;
  localparam logic [3:0]  HI_RST   = 4'h0;
  localparam logic [2:0]  CTRL_RST = 3'h0;
  localparam logic [11:0] CODE_RST = 12'h000;

  // ----------------------------------------
  // avalon register map (byte addresses)
  // ----------------------------------------
  localparam int AV_ADDR_W = 5;
  localparam logic [4:0] OFS_CMD  = 5'h00;
  localparam logic [4:0] OFS_HOLD = 5'h04;
  localparam logic [4:0] OFS_CONV = 5'h08;
  localparam logic [4:0] OFS_MODE = 5'h0c;
  localparam logic [4:0] OFS_WCNT = 5'h10;
  localparam int CMD_CLEAR_POS = 0;
  localparam int WCNT_W = 16;
  localparam logic [15:0] WCNT_RST = 16'h0000;
  localparam logic [31:0] RD_UNMAPPED = 32'h00000000;

  // ----------------------------------------
  // bus handshake states
  // ----------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;

endpackage

// File: rtl/pin_sync.sv
// two flip-flop synchroniser for a group of pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] pinIn,
  output var  logic [W-1:0] syncOut
);

  logic [W-1:0] stage1_ff;

  // ----------------------------------------
  // first stage feeds only the second
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stage1_ff <= RST_VAL;
      syncOut   <= RST_VAL;
    end else begin
      stage1_ff <= pinIn;
      syncOut   <= stage1_ff;
    end
  end

endmodule
`default_nettype wire

// File: rtl/hold_reg.sv
// loadable holding register with clear
`timescale 1ns/1ps
`default_nettype none
module hold_reg #(
  parameter int           W       = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         clear,
  input  wire logic         load,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] q_ff
);

  // ----------------------------------------
  // clear wins over load
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst || clear) begin
      q_ff <= RST_VAL;
    end else if (load) begin
      q_ff <= din;
    end
  end

endmodule
`default_nettype wire

// File: rtl/parallel_dac_write_control.sv
// parallel write front end of a 12-bit voltage output converter
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module parallel_dac_write_control
  import dac_wr_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // parallel host pins
  input  wire logic [dac_wr_pkg::DATA_W-1:0] dataBus,
  input  wire logic                      chipSel_n,
  input  wire logic                      writeStrobe_n,
  input  wire logic                      dest_select_hi,
  input  wire logic                      dest_select_lo,
  input  wire logic                      update_strobe_n,
  input  wire logic                      speed_select,
  input  wire logic                      power_select,
  // converter side
  output var  logic [dac_wr_pkg::CODE_W-1:0] dacCode,
  output var  logic                      fastMode,
  output var  logic                      powerDown,
  // avalon-mm slave
  input  wire logic [dac_wr_pkg::AV_ADDR_W-1:0] avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output var  logic [31:0]               avs_readdata,
  output var  logic                      avs_waitrequest
);

  import dac_wr_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam int PIN_W = DATA_W + 7;

  logic [PIN_W-1:0] pinRaw;
  logic [PIN_W-1:0] pinSync;

  assign pinRaw = {dataBus,
                   chipSel_n,
                   writeStrobe_n,
                   dest_select_hi,
                   dest_select_lo,
                   update_strobe_n,
                   speed_select,
                   power_select};

  // strobes and select idle high
  pin_sync #(
    .W       (PIN_W),
    .RST_VAL ({8'h00, 7'h6c})
  ) u_pin_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pinIn   (pinRaw),
    .syncOut (pinSync)
  );

  wire logic [DATA_W-1:0] dataS;
  wire logic              csS_n;
  wire logic              weS_n;
  wire logic [SEL_W-1:0]  selS;
  wire logic              updS_n;
  wire logic              speedS;
  wire logic              pwrS;

  assign dataS  = pinSync[PIN_W-1 -: DATA_W];
  assign csS_n  = pinSync[6];
  assign weS_n  = pinSync[5];
  assign selS   = pinSync[4:3];
  assign updS_n = pinSync[2];
  assign speedS = pinSync[1];
  assign pwrS   = pinSync[0];

  // ----------------------------------------
  // write strobe edge detection
  // ----------------------------------------
  logic weDly_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      weDly_ff <= 1'b1;
    end else begin
      weDly_ff <= weS_n;
    end
  end

  wire logic weRise;
  wire logic wrAccept;

  assign weRise   = weS_n & ~weDly_ff;
  assign wrAccept = weRise & ~csS_n;

  // ----------------------------------------
  // destination decode
  // ----------------------------------------
  wire logic ldLower;
  wire logic ldUpper;
  wire logic ldCtrl;
  wire logic ldAny;

  assign ldLower = wrAccept & (selS == SEL_LOWER);
  assign ldUpper = wrAccept & (selS == SEL_UPPER);
  assign ldCtrl  = wrAccept & (selS == SEL_CTRL);
  assign ldAny   = ldLower | ldUpper | ldCtrl;
  // SEL_RSVD raises no load strobe

  // ----------------------------------------
  // software clear command
  // ----------------------------------------
  wire logic swClear;

  // ----------------------------------------
  // holding latches and control register
  // ----------------------------------------
  logic [LO_W-1:0]   lowerHold;
  logic [HI_W-1:0]   upperHold;
  logic [CTRL_W-1:0] ctrlReg;

  hold_reg #(
    .W       (LO_W),
    .RST_VAL (LO_RST)
  ) u_lower_holding_latch (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clear   (swClear),
    .load    (ldLower),
    .din     (dataS),
    .q_ff    (lowerHold)
  );

  // only data bits 3..0 kept
  hold_reg #(
    .W       (HI_W),
    .RST_VAL (HI_RST)
  ) u_upper_holding_latch (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clear   (swClear),
    .load    (ldUpper),
    .din     (dataS[HI_W-1:0]),
    .q_ff    (upperHold)
  );

  // bits 7..3 dropped
  hold_reg #(
    .W       (CTRL_W),
    .RST_VAL (CTRL_RST)
  ) u_control_reg (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clear   (swClear),
    .load    (ldCtrl),
    .din     (dataS[CTRL_W-1:0]),
    .q_ff    (ctrlReg)
  );

  // ----------------------------------------
  // mode combination
  // ----------------------------------------
  wire logic speedBit;
  wire logic powerBit;
  wire logic reg_update_bit;
  wire logic nxt_fast;
  wire logic nxt_down;
  wire logic latchOpen;

  assign speedBit       = ctrlReg[CTRL_SPEED_POS];
  assign powerBit       = ctrlReg[CTRL_POWER_POS];
  assign reg_update_bit = ctrlReg[CTRL_UPDATE_POS];

  assign nxt_fast  = speedS | speedBit;
  assign nxt_down  = ~(pwrS & ~powerBit);
  assign latchOpen = ~(updS_n & ~reg_update_bit);

  // ----------------------------------------
  // converter latch and mode outputs
  // ----------------------------------------
  wire logic [CODE_W-1:0] holdCode;

  assign holdCode = {upperHold, lowerHold};

  logic [CODE_W-1:0] convLatch_ff;
  logic              fast_ff;
  logic              down_ff;

  always_ff @(posedge clk) begin
    if (sys_rst || swClear) begin
      convLatch_ff <= CODE_RST;
    end else if (latchOpen) begin
      convLatch_ff <= holdCode;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fast_ff <= 1'b0;
    end else begin
      fast_ff <= nxt_fast;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      down_ff <= 1'b1;
    end else begin
      down_ff <= nxt_down;
    end
  end

  assign dacCode   = convLatch_ff;
  assign fastMode  = fast_ff;
  assign powerDown = down_ff;

  // ----------------------------------------
  // counter of accepted writes that load a destination (SEL_RSVD writes not counted)
  // ----------------------------------------
  logic [WCNT_W-1:0] wrCount_ff;

  always_ff @(posedge clk) begin
    if (sys_rst || swClear) begin
      wrCount_ff <= WCNT_RST;
    end else if (ldAny) begin
      wrCount_ff <= wrCount_ff + 16'h0001;
    end
  end

  // ----------------------------------------
  // avalon handshake
  // ----------------------------------------
  bus_state_t busState_ff;
  bus_state_t nxt_busState;

  wire logic busReq;

  assign busReq = avs_read | avs_write;

  always_comb begin
    nxt_busState = busState_ff;
    unique case (busState_ff)
      BUS_IDLE: begin
        if (busReq) begin
          nxt_busState = BUS_ACK;
        end
      end
      BUS_ACK: begin
        nxt_busState = BUS_IDLE;
      end
      default: begin
        nxt_busState = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busState_ff <= BUS_IDLE;
    end else begin
      busState_ff <= nxt_busState;
    end
  end

  logic waitReq_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      waitReq_ff <= 1'b1;
    end else begin
      waitReq_ff <= (nxt_busState != BUS_ACK);
    end
  end

  assign avs_waitrequest = waitReq_ff;

  // ----------------------------------------
  // register write decode
  // ----------------------------------------
  wire logic busDone;
  wire logic cmdHit;

  assign busDone = busReq & ~waitReq_ff;
  assign cmdHit  = avs_address == OFS_CMD;
  assign swClear = busDone & avs_write & cmdHit
                 & avs_byteenable[0]
                 & avs_writedata[CMD_CLEAR_POS];

  // ----------------------------------------
  // register read mux
  // ----------------------------------------
  wire logic        holdHit;
  wire logic        convHit;
  wire logic        modeHit;
  wire logic        wcntHit;
  wire logic [31:0] modeWord;
  wire logic [31:0] rdMux;

  assign holdHit = avs_address == OFS_HOLD;
  assign convHit = avs_address == OFS_CONV;
  assign modeHit = avs_address == OFS_MODE;
  assign wcntHit = avs_address == OFS_WCNT;

  assign modeWord = {26'h0000000,
                     latchOpen,
                     down_ff,
                     fast_ff,
                     ctrlReg};

  assign rdMux =
    holdHit ? {20'h00000, holdCode} :
    convHit ? {20'h00000, convLatch_ff} :
    modeHit ? modeWord :
    wcntHit ? {16'h0000, wrCount_ff} :
    RD_UNMAPPED;

  logic [31:0] rdData_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdData_ff <= RD_UNMAPPED;
    end else if (avs_read && busState_ff == BUS_IDLE) begin
      rdData_ff <= rdMux;
    end
  end

  assign avs_readdata = rdData_ff;

endmodule
`default_nettype wire

// File: sim/parallel_dac_write_control_chk.sv
// assertion checker for the parallel converter write front end
`timescale 1ns/1ps
`default_nettype none
module parallel_dac_write_control_chk
  import dac_wr_pkg::*;
(
  input wire logic                          clk,
  input wire logic                          sys_rst,
  input wire logic                          chipSel_n,
  input wire logic                          update_strobe_n,
  input wire logic                          speed_select,
  input wire logic                          power_select,
  input wire logic [dac_wr_pkg::CODE_W-1:0] dacCode,
  input wire logic                          fastMode,
  input wire logic                          powerDown,
  input wire logic                          avs_read,
  input wire logic                          avs_write,
  input wire logic [31:0]                   avs_readdata,
  input wire logic                          avs_waitrequest
);
  import dac_wr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic req = avs_read || avs_write;
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  reset_clear_a: assert property ($fell(sys_rst) |-> dacCode == CODE_RST && powerDown && !fastMode)
    else $error("outputs not cleared by reset");
  fast_pin_a: assert property (speed_select [*4] |=> fastMode)
    else $error("speed pin high without fast mode");
  power_pin_a: assert property ((!power_select) [*4] |=> powerDown)
    else $error("power pin low without power down");
  code_stable_a: assert property ((chipSel_n && update_strobe_n && !avs_write) [*6]
    |=> $stable(dacCode))
    else $error("converter code moved without a write");
  wait_one_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait cycle");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  ack_cause_a: assert property (!avs_waitrequest |-> $past(req))
    else $error("waitrequest low without a request");
  rd_only_a: assert property ($changed(avs_readdata) |-> avs_read && !avs_waitrequest)
    else $error("read data changed outside a read completion");
  cover property (!chipSel_n ##1 $changed(dacCode));
  cover property (avs_read && !avs_waitrequest);
  cover property ($rose(powerDown));
endmodule
bind parallel_dac_write_control parallel_dac_write_control_chk u_chk (.*);
`default_nettype wire

// File: sim/dac_host_model.sv
// host model driving the parallel write pins
`timescale 1ns/1ps
`default_nettype none
module dac_host_model (
  input  wire logic       clk,
  output var  logic [7:0] dataBus,
  output var  logic       chipSel_n,
  output var  logic       writeStrobe_n,
  output var  logic       dest_select_hi,
  output var  logic       dest_select_lo,
  output var  logic       update_strobe_n,
  output var  logic       speed_select,
  output var  logic       power_select
);
  initial begin
    {dataBus, chipSel_n, writeStrobe_n} = {8'h5a, 2'b11};
    {dest_select_hi, dest_select_lo} = 2'b10;
    {update_strobe_n, speed_select, power_select} = 3'b101;
  end
  // strobe low then high for three cycles each, data held around the rise
  task automatic pinWrite(input logic [1:0] sel, input logic [7:0] d, input logic en);
    @(posedge clk);
    chipSel_n <= !en;
    writeStrobe_n <= 1'b0;
    {dest_select_hi, dest_select_lo} <= sel;
    dataBus <= d;
    repeat (3) @(posedge clk);
    writeStrobe_n <= 1'b1;
    repeat (3) @(posedge clk);
    chipSel_n <= 1'b1;
    dataBus <= ~d;
  endtask
  task automatic setPins(input logic upd, input logic speed, input logic pwr);
    @(posedge clk);
    {update_strobe_n, speed_select, power_select} <= {upd, speed, pwr};
  endtask
endmodule
`default_nettype wire

// File: sim/parallel_dac_write_control_tb.sv
// self-checking testbench for the parallel converter write front end
`timescale 1ns/1ps
`default_nettype none
module parallel_dac_write_control_tb;
  import dac_wr_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  dataBus;
  logic        chipSel_n, writeStrobe_n, dest_select_hi, dest_select_lo;
  logic        update_strobe_n, speed_select, power_select;
  logic [11:0] dacCode;
  logic        fastMode, powerDown;
  int          n_fail = 0;
  int          n_tests = 0;
  always #20 clk = ~clk;
  parallel_dac_write_control u_dut (.*);
  dac_host_model u_host (.*);
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic avAccess(input logic wr, input logic [4:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rdChk(input string nm, input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    avAccess(1'b0, a, 32'h0, q);
    check(nm, e, q);
  endtask
  task automatic outChk(input logic [11:0] code, input logic fast, input logic down);
    repeat (8) @(posedge clk);
    check("dacCode", {20'h0, code}, {20'h0, dacCode});
    check("fastMode", {31'h0, fast}, {31'h0, fastMode});
    check("powerDown", {31'h0, down}, {31'h0, powerDown});
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    logic [31:0] q;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    outChk(12'h000, 1'b0, 1'b0);
    rdChk("mode", OFS_MODE, 32'h0);
    $display("test reset done");
    u_host.pinWrite(SEL_UPPER, 8'hab, 1'b1);
    u_host.pinWrite(SEL_LOWER, 8'hcd, 1'b1);
    u_host.pinWrite(SEL_RSVD, 8'hff, 1'b1);
    u_host.pinWrite(SEL_LOWER, 8'h11, 1'b0);
    rdChk("hold", OFS_HOLD, 32'hbcd);
    outChk(12'h000, 1'b0, 1'b0);
    u_host.setPins(1'b0, 1'b0, 1'b1);
    outChk(12'hbcd, 1'b0, 1'b0);
    u_host.pinWrite(SEL_LOWER, 8'h12, 1'b1);
    outChk(12'hb12, 1'b0, 1'b0);
    $display("test select done");
    for (int i = 0; i < 32; i++) begin
      u_host.setPins(1'b1, i[3], i[4]);
      u_host.pinWrite(SEL_CTRL, 8'hf8 | i[7:0], 1'b1);
      outChk(12'hb12, i[3] | i[0], !(i[4] && !i[1]));
      rdChk("mode", OFS_MODE, {26'h0, i[2], !(i[4] && !i[1]), i[3] | i[0], i[2:0]});
    end
    u_host.setPins(1'b1, 1'b0, 1'b1);
    $display("test modes done");
    u_host.pinWrite(SEL_CTRL, 8'h00, 1'b1);
    u_host.pinWrite(SEL_UPPER, 8'hff, 1'b1);
    u_host.pinWrite(SEL_LOWER, 8'hff, 1'b1);
    outChk(12'hb12, 1'b0, 1'b0);
    u_host.pinWrite(SEL_CTRL, 8'h04, 1'b1);
    outChk(12'hfff, 1'b0, 1'b0);
    $display("test update done");
    avAccess(1'b1, OFS_HOLD, 32'h0, q);
    rdChk("hold", OFS_HOLD, 32'hfff);
    rdChk("unmapped", 5'h14, RD_UNMAPPED);
    rdChk("wcnt", OFS_WCNT, 32'h27);
    avs_byteenable <= 4'he;
    avAccess(1'b1, OFS_CMD, 32'h1, q);
    rdChk("hold", OFS_HOLD, 32'hfff);
    avs_byteenable <= 4'hf;
    avAccess(1'b1, OFS_CMD, 32'h1, q);
    rdChk("conv", OFS_CONV, 32'h0);
    rdChk("wcnt", OFS_WCNT, 32'h0);
    outChk(12'h000, 1'b0, 1'b0);
    $display("test bus done");
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    complete_run();
  end
endmodule
`default_nettype wire
